// File: logic/sso_pkg.sv
package sso_pkg;

  // Position of this slice in a cascaded word.
  typedef enum logic [1:0] {
    SSO_RANK_LOWEST = 2'b00,
    SSO_RANK_MIDDLE = 2'b01,
    SSO_RANK_HIGHEST = 2'b10
  } sso_rank_t;

  // Operation forms as driven by the microprogram controller.
  typedef enum logic [3:0] {
    SSO_FORM_I = 4'h1,
    SSO_FORM_II = 4'h2,
    SSO_FORM_III = 4'h3,
    SSO_FORM_IV = 4'h4,
    SSO_FORM_V = 4'h5,
    SSO_FORM_VI = 4'h6,
    SSO_FORM_VII = 4'h7,
    SSO_FORM_VIII = 4'h8,
    SSO_FORM_IX = 4'h9
  } sso_form_t;

  typedef struct packed {
    sso_form_t form;
    logic shift_left;
    logic shift_arith;
    logic dest_xwr;
    logic load_pc;
    logic load_mc;
  } sso_op_t;

  // One bit per shift-edge terminal.
  typedef struct packed {
    logic work_reg_left_edge;
    logic work_reg_right_edge;
    logic ext_reg_left_edge;
    logic ext_reg_right_edge;
  } sso_edge_t;

  localparam int SSO_WIDTH = 4;
  localparam logic [1:0] SSO_DOUT_SUM = 2'b00;
  localparam logic [1:0] SSO_DOUT_XWR = 2'b01;
  localparam logic [1:0] SSO_DOUT_WR = 2'b10;
  localparam logic [1:0] SSO_DOUT_HIZ = 2'b11;

  localparam int SSO_AXI_AW = 4;
  localparam logic [3:0] SSO_OFS_CTRL = 4'h0;
  localparam logic [3:0] SSO_OFS_STATUS = 4'h4;
  localparam int SSO_CTRL_RANK_LSB = 0;
  localparam logic [1:0] SSO_CTRL_RESET = 2'h0;
  localparam logic [3:0] SSO_REG_RESET = 4'h0;
  localparam logic [1:0] SSO_RESP_OKAY = 2'b00;
  localparam logic [1:0] SSO_RESP_SLVERR = 2'b10;

endpackage : sso_pkg

// File: logic/sso_slice.sv
`timescale 1ns/1ps
module sso_slice (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire sso_pkg::sso_op_t op,
  input wire logic [3:0] a_operand,
  input wire logic [3:0] alu_sum,
  input wire logic alu_overflow,
  input wire sso_pkg::sso_edge_t edge_in,
  output sso_pkg::sso_edge_t edge_out,
  output sso_pkg::sso_edge_t edge_oe,
  input wire logic out_select_high,
  input wire logic out_select_low,
  output logic [3:0] data_out,
  output logic data_out_oe,
  input wire logic step_program_counter_n,
  input wire logic step_memory_counter_n,
  input wire logic count_carry_in_n,
  output logic count_carry_out_n,
  input wire logic address_out_select,
  output logic [3:0] address_out,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////////
  // Shift helpers.

  function automatic logic [3:0] shift4(input logic [3:0] src, input logic left,
                                        input logic fill);
    shift4 = left ? {src[2:0], fill} : {fill, src[3:1]};
  endfunction : shift4

  // End fill: the outermost slice supplies zero or sign, others take the neighbour's bit.
  function automatic logic end_fill(input logic left, input logic arith, input logic msb,
                                    input logic lowest, input logic highest,
                                    input logic from_left, input logic from_right);
    if (left) begin
      end_fill = lowest ? 1'b0 : from_right;
    end else if (highest) begin
      end_fill = arith ? msb : 1'b0;
    end else begin
      end_fill = from_left;
    end
  endfunction : end_fill

  ////////////////////////////////////////////////////////////////////////////////
  // Register file: rank control and a read-only snapshot of the datapath.

  sso_pkg::sso_rank_t rank_ff;
  logic [3:0] wr_ff;
  logic [3:0] xwr_ff;
  logic [3:0] pc_value;
  logic [3:0] mc_value;
  logic is_lowest;
  logic is_highest;

  logic aw_held_ff;
  logic [3:0] aw_addr_ff;
  logic w_held_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic do_write;

  assign is_lowest = (rank_ff == sso_pkg::SSO_RANK_LOWEST);
  assign is_highest = (rank_ff == sso_pkg::SSO_RANK_HIGHEST);
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // The status word is read-only, so only the control word accepts data.
  always_ff @(posedge clock) begin
    if (rst) begin
      rank_ff <= sso_pkg::sso_rank_t'(sso_pkg::SSO_CTRL_RESET);
      bvalid_ff <= 1'b0;
      bresp_ff <= sso_pkg::SSO_RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid_ff <= 1'b1;
        if (aw_addr_ff == sso_pkg::SSO_OFS_CTRL) begin
          bresp_ff <= sso_pkg::SSO_RESP_OKAY;
          if (w_strb_ff[0]) begin
            rank_ff <= sso_pkg::sso_rank_t'(w_data_ff[sso_pkg::SSO_CTRL_RANK_LSB +: 2]);
          end
        end else if (aw_addr_ff == sso_pkg::SSO_OFS_STATUS) begin
          bresp_ff <= sso_pkg::SSO_RESP_OKAY;
        end else begin
          bresp_ff <= sso_pkg::SSO_RESP_SLVERR;
        end
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= sso_pkg::SSO_RESP_OKAY;
      rdata_ff <= 32'h0;
    end else if (ce) begin
      if (s_axi_arvalid && !rvalid_ff) begin
        rvalid_ff <= 1'b1;
        if (s_axi_araddr == sso_pkg::SSO_OFS_CTRL) begin
          rresp_ff <= sso_pkg::SSO_RESP_OKAY;
          rdata_ff <= {30'h0, rank_ff};
        end else if (s_axi_araddr == sso_pkg::SSO_OFS_STATUS) begin
          rresp_ff <= sso_pkg::SSO_RESP_OKAY;
          rdata_ff <= {16'h0, pc_value, mc_value, xwr_ff, wr_ff};
        end else begin
          rresp_ff <= sso_pkg::SSO_RESP_SLVERR;
          rdata_ff <= 32'h0;
        end
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Shift transfer network.

  logic [3:0] nxt_wr;
  logic [3:0] nxt_xwr;
  logic [3:0] sum_prime;
  logic shift_ovf;

  always_comb begin
    logic [3:0] src;
    logic [7:0] dbl;
    logic fill;
    logic ext_chain;
    src = 4'h0;
    dbl = 8'h0;
    fill = 1'b0;
    ext_chain = 1'b0;
    nxt_wr = wr_ff;
    nxt_xwr = xwr_ff;
    sum_prime = alu_sum;
    shift_ovf = 1'b0;
    edge_out = '0;
    edge_oe = '0;
    case (op.form)
      sso_pkg::SSO_FORM_I: begin
        if (op.dest_xwr) begin
          nxt_xwr = alu_sum;
        end else begin
          nxt_wr = alu_sum;
        end
      end
      sso_pkg::SSO_FORM_II, sso_pkg::SSO_FORM_VI: begin
        // On a right shift the low bit of the upper half feeds the extended register directly.
        dbl = (op.form == sso_pkg::SSO_FORM_II) ? {alu_sum, xwr_ff} : {wr_ff, xwr_ff};
        fill = end_fill(op.shift_left, op.shift_arith, dbl[7], is_lowest, is_highest,
                        edge_in.work_reg_left_edge, edge_in.ext_reg_right_edge);
        if (op.shift_left) begin
          {nxt_wr, nxt_xwr} = {dbl[6:0], fill};
          edge_out.work_reg_left_edge = dbl[7];
          edge_oe.work_reg_left_edge = 1'b1;
          shift_ovf = op.shift_arith && (dbl[7] ^ dbl[6]);
        end else begin
          {nxt_wr, nxt_xwr} = {fill, dbl[7:1]};
          edge_out.ext_reg_right_edge = dbl[0];
          edge_oe.ext_reg_right_edge = 1'b1;
        end
      end
      sso_pkg::SSO_FORM_III, sso_pkg::SSO_FORM_IV, sso_pkg::SSO_FORM_V: begin
        if (op.form == sso_pkg::SSO_FORM_III) begin
          src = alu_sum;
        end else if (op.form == sso_pkg::SSO_FORM_IV) begin
          src = a_operand;
        end else begin
          src = op.dest_xwr ? xwr_ff : wr_ff;
        end
        ext_chain = op.dest_xwr && (op.form != sso_pkg::SSO_FORM_IV);
        fill = ext_chain ?
          end_fill(op.shift_left, op.shift_arith, src[3], is_lowest, is_highest,
                   edge_in.ext_reg_left_edge, edge_in.ext_reg_right_edge) :
          end_fill(op.shift_left, op.shift_arith, src[3], is_lowest, is_highest,
                   edge_in.work_reg_left_edge, edge_in.work_reg_right_edge);
        if (op.form == sso_pkg::SSO_FORM_IV) begin
          sum_prime = shift4(src, op.shift_left, fill);
        end else if (ext_chain) begin
          nxt_xwr = shift4(src, op.shift_left, fill);
        end else begin
          nxt_wr = shift4(src, op.shift_left, fill);
        end
        if (op.shift_left) begin
          shift_ovf = op.shift_arith && (src[3] ^ src[2]);
          if (ext_chain) begin
            edge_out.ext_reg_left_edge = src[3];
            edge_oe.ext_reg_left_edge = 1'b1;
          end else begin
            edge_out.work_reg_left_edge = src[3];
            edge_oe.work_reg_left_edge = 1'b1;
          end
        end else if (ext_chain) begin
          edge_out.ext_reg_right_edge = src[0];
          edge_oe.ext_reg_right_edge = 1'b1;
        end else begin
          edge_out.work_reg_right_edge = src[0];
          edge_oe.work_reg_right_edge = 1'b1;
        end
      end
      sso_pkg::SSO_FORM_IX: begin
        sum_prime = 4'h0;
      end
      default: begin
        nxt_wr = wr_ff;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ff <= sso_pkg::SSO_REG_RESET;
      xwr_ff <= sso_pkg::SSO_REG_RESET;
    end else if (ce) begin
      wr_ff <= nxt_wr;
      xwr_ff <= nxt_xwr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output selectors.

  logic [1:0] dout_sel;
  assign dout_sel = {out_select_high, out_select_low};

  always_comb begin
    data_out_oe = (dout_sel != sso_pkg::SSO_DOUT_HIZ);
    case (dout_sel)
      sso_pkg::SSO_DOUT_SUM: data_out = sum_prime;
      sso_pkg::SSO_DOUT_XWR: data_out = xwr_ff;
      sso_pkg::SSO_DOUT_WR: data_out = wr_ff;
      default: data_out = 4'h0;
    endcase
  end

  // Address out is a plain mux so addresses are usable within the same cycle.
  assign address_out = address_out_select ? pc_value : mc_value;

  ////////////////////////////////////////////////////////////////////////////////
  // Program and memory counters.

  logic load_pc;
  logic load_mc;
  logic pc_carry_n;
  logic mc_carry_n;

  assign load_pc = op.load_pc && (op.form == sso_pkg::SSO_FORM_I ||
                                  op.form == sso_pkg::SSO_FORM_VIII);
  assign load_mc = op.load_mc && (op.form == sso_pkg::SSO_FORM_I ||
                                  op.form == sso_pkg::SSO_FORM_III);

  sso_slice_counter u_program_counter (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .load(load_pc),
    .load_val(alu_sum),
    .step_n(step_program_counter_n),
    .carry_in_n(count_carry_in_n),
    .lowest(is_lowest),
    .value(pc_value),
    .carry_out_n(pc_carry_n)
  );

  sso_slice_counter u_memory_counter (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .load(load_mc),
    .load_val(alu_sum),
    .step_n(step_memory_counter_n),
    .carry_in_n(count_carry_in_n),
    .lowest(is_lowest),
    .value(mc_value),
    .carry_out_n(mc_carry_n)
  );

  // The top slice has no one to carry into, so the pin carries overflow, high when set.
  always_comb begin
    if (is_highest) begin
      count_carry_out_n = shift_ovf || (op.form == sso_pkg::SSO_FORM_I && alu_overflow);
    end else begin
      count_carry_out_n = pc_carry_n && mc_carry_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_step_pc_lowest_two;
    ce && is_lowest && !step_program_counter_n && count_carry_in_n && !load_pc;
  endsequence

  sequence s_step_pc_upper_hold;
    ce && !is_lowest && !step_program_counter_n && count_carry_in_n && !load_pc;
  endsequence

  a_arith_sign_keep: assert property (ce && is_highest && op.form == sso_pkg::SSO_FORM_V &&
    !op.dest_xwr && !op.shift_left && op.shift_arith |=>
    wr_ff == {$past(wr_ff[3]), $past(wr_ff[3:1])})
    else $error("arithmetic right shift lost the sign");

  a_double_link: assert property (ce && op.form == sso_pkg::SSO_FORM_VI && op.shift_left |=>
    wr_ff[0] == $past(xwr_ff[3]) && xwr_ff[3:1] == $past(xwr_ff[2:0]))
    else $error("double shift dropped the middle bit");

  a_form_two_right: assert property (ce && op.form == sso_pkg::SSO_FORM_II && !op.shift_left |=>
    xwr_ff[3] == $past(alu_sum[0]) && wr_ff[2:0] == $past(alu_sum[3:1]))
    else $error("form II right shift wrong");

  a_lsb_zero_fill: assert property (ce && is_lowest && op.form == sso_pkg::SSO_FORM_V &&
    op.shift_left && !op.dest_xwr |=> wr_ff == {$past(wr_ff[2:0]), 1'b0})
    else $error("lowest slice left shift not zero filled");

  a_dout_select: assert property (dout_sel == sso_pkg::SSO_DOUT_WR |->
    data_out_oe && data_out == wr_ff)
    else $error("data out does not show working register");

  a_dout_release: assert property (out_select_high && out_select_low |-> !data_out_oe)
    else $error("data out driven while released");

  a_load_gate: assert property (ce && op.load_mc && step_memory_counter_n &&
    op.form == sso_pkg::SSO_FORM_VIII |=> $stable(mc_value))
    else $error("memory counter loaded in a barred form");

  a_step_by_two: assert property (s_step_pc_lowest_two |=>
    pc_value == 4'($past(pc_value) + 4'h2))
    else $error("lowest slice did not step by two");

  a_upper_hold: assert property (s_step_pc_upper_hold |=> $stable(pc_value))
    else $error("upper slice stepped without carry");

  a_counter_idle: assert property (ce && step_program_counter_n && !load_pc |=>
    $stable(pc_value))
    else $error("program counter moved while idle");

  a_addr_select: assert property (address_out == (address_out_select ? pc_value : mc_value))
    else $error("address out shows the wrong counter");

  a_top_flag: assert property (is_highest && op.form == sso_pkg::SSO_FORM_I && alu_overflow |->
    count_carry_out_n)
    else $error("overflow not reported on top slice");

endmodule : sso_slice

// File: logic/sso_slice_counter.sv
`timescale 1ns/1ps
module sso_slice_counter (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [3:0] load_val,
  input wire logic step_n,
  input wire logic carry_in_n,
  input wire logic lowest,
  output logic [3:0] value,
  output logic carry_out_n
);

  logic [3:0] value_ff;
  logic [3:0] nxt_value;
  logic [4:0] sum5;
  logic [4:0] amount;

  // The lowest slice steps by two when its carry input is high; upper slices only follow a carry.
  always_comb begin
    if (lowest) begin
      amount = carry_in_n ? 5'h02 : 5'h01;
    end else begin
      amount = carry_in_n ? 5'h00 : 5'h01;
    end
    sum5 = {1'b0, value_ff} + amount;
    carry_out_n = !(!step_n && !load && sum5[4]);
    if (load) begin
      nxt_value = load_val;
    end else if (!step_n) begin
      nxt_value = sum5[3:0];
    end else begin
      nxt_value = value_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      value_ff <= sso_pkg::SSO_REG_RESET;
    end else if (ce) begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;

  a_wrap_zero: assert property (@(posedge clock) disable iff (rst)
    (ce && !load && !step_n && !carry_in_n && value_ff == 4'hf) |=> value_ff == 4'h0)
    else $error("counter did not wrap to zero");

endmodule : sso_slice_counter

// File: verif/sso_neighbour_model.sv
`timescale 1ns/1ps
// Stands for the adjacent slices: each edge terminal is one shared wire, driven by whichever
// side enables it, and the lower slice's carry output feeds this slice's carry input.
module sso_neighbour_model (
  input wire sso_pkg::sso_edge_t dut_out,
  input wire sso_pkg::sso_edge_t dut_oe,
  input wire sso_pkg::sso_edge_t far_drive,
  input wire logic lower_carry_n,
  output sso_pkg::sso_edge_t edge_in,
  output logic count_carry_in_n
);
  assign edge_in = (dut_out & dut_oe) | (far_drive & ~dut_oe);
  assign count_carry_in_n = lower_carry_n;
endmodule : sso_neighbour_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  sso_pkg::sso_op_t op = '0;
  logic [3:0] a_operand = 4'h6;
  logic [3:0] alu_sum = 4'h0;
  logic alu_overflow = 1'b0;
  sso_pkg::sso_edge_t edge_in, edge_out, edge_oe, cap_eo, cap_eoe;
  sso_pkg::sso_edge_t far_drive = 4'hf;
  logic lower_carry_n = 1'b0;
  logic carry_in_n, count_carry_out_n, data_out_oe, cap_cco;
  logic out_select_high = 1'b0;
  logic out_select_low = 1'b0;
  logic step_pc_n = 1'b1;
  logic step_mc_n = 1'b1;
  logic address_out_select = 1'b0;
  logic [3:0] data_out, address_out, cap_out;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int err_count = 0;
  int checked = 0;

  always #50 clock = ~clock;

  sso_neighbour_model nb (.dut_out(edge_out), .dut_oe(edge_oe), .far_drive(far_drive),
    .lower_carry_n(lower_carry_n), .edge_in(edge_in), .count_carry_in_n(carry_in_n));

  sso_slice DUT (.clock(clock), .rst(rst), .ce(ce), .op(op), .a_operand(a_operand),
    .alu_sum(alu_sum), .alu_overflow(alu_overflow), .edge_in(edge_in), .edge_out(edge_out),
    .edge_oe(edge_oe), .out_select_high(out_select_high), .out_select_low(out_select_low),
    .data_out(data_out), .data_out_oe(data_out_oe), .step_program_counter_n(step_pc_n),
    .step_memory_counter_n(step_mc_n), .count_carry_in_n(carry_in_n),
    .count_carry_out_n(count_carry_out_n), .address_out_select(address_out_select),
    .address_out(address_out), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Ready is sampled mid-cycle, where it is settled, and acted on at the following edge.
  task axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_go, w_go, bv;
    bv = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bv) begin
      @(negedge clock);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      bv = bvalid;
      r = bresp;
      @(posedge clock);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (bv) bready <= 1'b0;
    end
  endtask : axi_write

  task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_go, rv;
    rv = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rv) begin
      @(negedge clock);
      ar_go = arvalid && arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ar_go) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
    end
  endtask : axi_read

  task st(input logic [15:0] exp);
    axi_read(sso_pkg::SSO_OFS_STATUS, rd, resp);
    chk("status", {16'h0, rd[15:0]}, {16'h0, exp});
  endtask : st

  task set_rank(input logic [1:0] rank);
    axi_write(sso_pkg::SSO_OFS_CTRL, {30'h0, rank}, resp);
    chk("ctrl write resp", {30'h0, resp}, {30'h0, sso_pkg::SSO_RESP_OKAY});
  endtask : set_rank

  // Flags are shift_left, shift_arith, dest_xwr, load_pc, load_mc; steps are pc, mc, low active.
  task run_op(input sso_pkg::sso_form_t f, input logic [4:0] fl, input logic [3:0] s,
              input logic [1:0] steps_n);
    @(posedge clock);
    op <= sso_pkg::sso_op_t'({f, fl});
    alu_sum <= s;
    {step_pc_n, step_mc_n} <= steps_n;
    @(negedge clock);
    cap_eo = edge_out;
    cap_eoe = edge_oe;
    cap_out = data_out;
    cap_cco = count_carry_out_n;
    @(posedge clock);
    op <= '0;
    {step_pc_n, step_mc_n} <= 2'b11;
  endtask : run_op

  task ao(input logic [3:0] mc, input logic [3:0] pc);
    @(posedge clock);
    address_out_select <= 1'b0;
    @(negedge clock);
    chk("address_out mc", {28'h0, address_out}, {28'h0, mc});
    @(posedge clock);
    address_out_select <= 1'b1;
    @(negedge clock);
    chk("address_out pc", {28'h0, address_out}, {28'h0, pc});
    @(posedge clock);
  endtask : ao

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    err_count++;
    report_and_stop();
  end

  initial begin
    logic [3:0] dexp [4];
    dexp = '{4'h3, 4'h5, 4'ha, 4'h0};
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    axi_read(sso_pkg::SSO_OFS_CTRL, rd, resp);
    chk("ctrl reset", rd, 32'h0);
    chk("ctrl resp", {30'h0, resp}, {30'h0, sso_pkg::SSO_RESP_OKAY});
    st(16'h0000);
    axi_read(4'h8, rd, resp);
    chk("unmapped read resp", {30'h0, resp}, {30'h0, sso_pkg::SSO_RESP_SLVERR});
    axi_write(4'hc, 32'h1, resp);
    chk("unmapped write resp", {30'h0, resp}, {30'h0, sso_pkg::SSO_RESP_SLVERR});
    $display("test registers done");
    run_op(sso_pkg::SSO_FORM_I, 5'b00000, 4'ha, 2'b11);
    run_op(sso_pkg::SSO_FORM_I, 5'b00100, 4'h5, 2'b11);
    @(posedge clock);
    alu_sum <= 4'h3;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {out_select_high, out_select_low} <= i[1:0];
      @(negedge clock);
      chk("data_out_oe", {31'h0, data_out_oe}, {31'h0, i != 3});
      if (i < 3) chk("data_out", {28'h0, data_out}, {28'h0, dexp[i]});
    end
    $display("test data out done");
    @(posedge clock);
    {out_select_high, out_select_low} <= 2'b00;
    run_op(sso_pkg::SSO_FORM_V, 5'b11000, 4'h3, 2'b11);
    chk("left edge out", {30'h0, cap_eo[3], cap_eoe[3]}, 32'h3);
    st(16'h0054);
    run_op(sso_pkg::SSO_FORM_VI, 5'b11000, 4'h3, 2'b11);
    st(16'h00a8);
    run_op(sso_pkg::SSO_FORM_VI, 5'b00000, 4'h3, 2'b11);
    chk("ext right edge out", {30'h0, cap_eo[0], cap_eoe[0]}, 32'h1);
    st(16'h005c);
    run_op(sso_pkg::SSO_FORM_III, 5'b10100, 4'h9, 2'b11);
    st(16'h002c);
    run_op(sso_pkg::SSO_FORM_II, 5'b10000, 4'h3, 2'b11);
    st(16'h0046);
    run_op(sso_pkg::SSO_FORM_IV, 5'b11000, 4'h3, 2'b11);
    chk("shifted operand", {28'h0, cap_out}, 32'hc);
    ce <= 1'b0;
    run_op(sso_pkg::SSO_FORM_V, 5'b11000, 4'h3, 2'b11);
    ce <= 1'b1;
    st(16'h0046);
    set_rank(2'b10);
    run_op(sso_pkg::SSO_FORM_I, 5'b00000, 4'h9, 2'b11);
    run_op(sso_pkg::SSO_FORM_V, 5'b01000, 4'h9, 2'b11);
    st(16'h004c);
    for (int i = 1; i >= 0; i--) begin
      alu_overflow <= i[0];
      run_op(sso_pkg::SSO_FORM_I, 5'b00100, 4'h4, 2'b11);
      chk("overflow pin", {31'h0, cap_cco}, {31'h0, i[0]});
    end
    $display("test shifts done");
    set_rank(2'b00);
    run_op(sso_pkg::SSO_FORM_I, 5'b00011, 4'hf, 2'b11);
    ao(4'hf, 4'hf);
    lower_carry_n <= 1'b0;
    run_op(sso_pkg::SSO_FORM_IX, 5'b00000, 4'h0, 2'b10);
    chk("carry out at wrap", {31'h0, cap_cco}, 32'h0);
    ao(4'h0, 4'hf);
    lower_carry_n <= 1'b1;
    run_op(sso_pkg::SSO_FORM_IX, 5'b00000, 4'h0, 2'b10);
    run_op(sso_pkg::SSO_FORM_IX, 5'b00000, 4'h0, 2'b01);
    ao(4'h2, 4'h1);
    set_rank(2'b01);
    run_op(sso_pkg::SSO_FORM_IX, 5'b00000, 4'h0, 2'b01);
    lower_carry_n <= 1'b0;
    run_op(sso_pkg::SSO_FORM_IX, 5'b00000, 4'h0, 2'b01);
    run_op(sso_pkg::SSO_FORM_IX, 5'b00000, 4'h0, 2'b11);
    ao(4'h2, 4'h2);
    run_op(sso_pkg::SSO_FORM_III, 5'b00011, 4'h7, 2'b11);
    ao(4'h7, 4'h2);
    run_op(sso_pkg::SSO_FORM_VIII, 5'b00011, 4'h9, 2'b11);
    ao(4'h7, 4'h9);
    $display("test counters done");
    report_and_stop();
  end
endmodule : tb_top
